// ===== ccr_config_regs.sv
// Converter configuration register bank behind the three-wire serial port
`timescale 1ns/100ps
`include "ccr_regs.svh"
module ccr_config_regs
    import ccr_pkg::*;
#(
    parameter logic [7:0] PART_ID       = 8'h5A,  // Arbitrary value
    parameter logic [1:0] GRADE_VARIANT = 2'h3    // Arbitrary value
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       sclk_i,
    input  wire logic       csb_n_i,
    input  wire logic       sdio_i,
    output logic            sdio_o,
    output logic            sdio_drive_n_o,
    output logic            lsb_first_o,
    output logic [7:0]      chan_data_en_o,
    output logic            frame_clock_output_lane_o,
    output logic            data_clock_output_lane_o,
    output logic            lna_bypass_o,
    output logic [2:0]      op_mode_o,
    output logic            dcs_en_o
);

    // ============================================================
    // Helpers
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction : rev8

    function automatic logic mapped(input logic [12:0] a);
        return (a <= `CCR_ADDR_GRADE) || (a == `CCR_ADDR_SEL_UPPER) || (a == `CCR_ADDR_SEL_LOWER)
            || (a == `CCR_ADDR_UPDATE) || ((a >= `CCR_ADDR_OP_MODE) && (a <= `CCR_ADDR_FUNC_LAST));
    endfunction : mapped

    ccr_pins_s pins;

    ccr_pin_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .sclk_i     (sclk_i),
        .csb_n_i    (csb_n_i),
        .sdio_i     (sdio_i),
        .pins_o     (pins)
    );

    // ============================================================
    // Register file state
    logic [7:0] port_cfg;
    logic [7:0] sel_hi_m;
    logic [7:0] sel_lo_m;
    logic [7:0] sel_hi;
    logic [7:0] sel_lo;
    logic [7:0] op_mode;
    logic [7:0] clk_ctrl;
    logic       upd_pend;
    logic [7:0] next_port_cfg;
    logic [7:0] next_sel_hi_m;
    logic [7:0] next_sel_lo_m;
    logic [7:0] next_sel_hi;
    logic [7:0] next_sel_lo;
    logic [7:0] next_op_mode;
    logic [7:0] next_clk_ctrl;
    logic       next_upd_pend;
    logic       soft_rst;
    ccr_wr_s    wr;

    // ============================================================
    // Serial engine state
    ccr_state_e  state;
    logic [3:0]  bit_cnt;
    logic [14:0] shift_in;
    logic [12:0] addr;
    logic [1:0]  len;
    logic [1:0]  byte_cnt;
    logic [7:0]  rd_shift;
    logic        sdio_q;
    logic        drive_n;
    ccr_state_e  next_state;
    logic [3:0]  next_bit_cnt;
    logic [14:0] next_shift_in;
    logic [12:0] next_addr;
    logic [1:0]  next_len;
    logic [1:0]  next_byte_cnt;
    logic [7:0]  next_rd_shift;
    logic        next_sdio_q;
    logic        next_drive_n;

    logic        lsb;
    logic [15:0] word_in;
    logic [15:0] instr;
    logic [12:0] step_addr;
    logic [12:0] ld_addr;
    logic [7:0]  rd_byte;
    logic        ld_event;

    // Either mirrored copy selects the order, so a host using either order sets it
    // mirrored order bits
    assign lsb       = port_cfg[`CCR_BIT_ORDER_HI] | port_cfg[`CCR_BIT_ORDER_LO];
    assign word_in   = {shift_in, pins.sdata};
    assign instr     = lsb ? {rev8(word_in[7:0]), rev8(word_in[15:8])} : word_in;
    assign step_addr = lsb ? addr + 13'h0001 : addr - 13'h0001;
    assign ld_addr   = (state == CCR_ST_INSTR) ? instr[12:0] : step_addr;

    // ============================================================
    // Readback decode
    // three register groups
    always_comb begin
        rd_byte = 8'h00;
        case (ld_addr)
            `CCR_ADDR_PORT_CFG:  rd_byte = port_cfg;
            `CCR_ADDR_PART_ID:   rd_byte = PART_ID;
            `CCR_ADDR_GRADE:     rd_byte = {2'h0, GRADE_VARIANT, 4'h0};
            `CCR_ADDR_SEL_UPPER: rd_byte = sel_hi_m;
            `CCR_ADDR_SEL_LOWER: rd_byte = sel_lo_m;
            `CCR_ADDR_UPDATE:    rd_byte = {7'h00, upd_pend};
            `CCR_ADDR_OP_MODE:   rd_byte = op_mode;
            `CCR_ADDR_CLK_CTRL:  rd_byte = clk_ctrl;
            default:             rd_byte = 8'h00;
        endcase
    end

    // ============================================================
    // Serial frame engine
    always_comb begin
        next_state    = state;
        next_bit_cnt  = bit_cnt;
        next_shift_in = shift_in;
        next_addr     = addr;
        next_len      = len;
        next_byte_cnt = byte_cnt;
        next_rd_shift = rd_shift;
        next_sdio_q   = sdio_q;
        next_drive_n  = drive_n;
        wr            = '0;
        ld_event      = 1'b0;
        // Releasing select mid-byte drops the frame and waits for a new instruction
        if (!pins.cs_active) begin
            next_state   = CCR_ST_INSTR;
            next_bit_cnt = 4'h0;
            next_drive_n = 1'b1;
        end else if (pins.sclk_rise) begin
            next_shift_in = word_in[14:0];
            next_bit_cnt  = bit_cnt + 4'h1;
            case (state)
                CCR_ST_INSTR: begin
                    if (bit_cnt == 4'hF) begin
                        next_addr     = instr[12:0];
                        next_len      = instr[`CCR_INSTR_LEN_LSB +: 2];
                        next_byte_cnt = 2'h0;
                        next_bit_cnt  = 4'h0;
                        if (instr[`CCR_BIT_INSTR_READ]) begin
                            next_state    = CCR_ST_READ;
                            next_rd_shift = lsb ? rev8(rd_byte) : rd_byte;
                            ld_event      = 1'b1;
                        end else begin
                            next_state = CCR_ST_WRITE;
                        end
                    end
                end
                CCR_ST_WRITE, CCR_ST_READ: begin
                    if (bit_cnt[2:0] == 3'h7) begin
                        next_bit_cnt = 4'h0;
                        next_addr    = step_addr;
                        if (state == CCR_ST_WRITE) begin
                            wr.en   = 1'b1;
                            wr.addr = addr;
                            wr.data = lsb ? rev8(word_in[7:0]) : word_in[7:0];
                        end else begin
                            next_rd_shift = lsb ? rev8(rd_byte) : rd_byte;
                            ld_event      = 1'b1;
                        end
                        // Length code 3 streams until select is released
                        if (len != 2'h3 && byte_cnt == len) begin
                            next_state = CCR_ST_DONE;
                        end
                        next_byte_cnt = byte_cnt + 2'h1;
                    end
                end
                CCR_ST_DONE: next_bit_cnt = bit_cnt;
                default:     next_state = CCR_ST_INSTR;
            endcase
        end else if (pins.sclk_fall && state == CCR_ST_READ) begin
            next_sdio_q   = rd_shift[7];
            next_rd_shift = {rd_shift[6:0], 1'b0};
            next_drive_n  = 1'b0;
        end else if (pins.sclk_fall) begin
            next_drive_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state    <= CCR_ST_INSTR;
            bit_cnt  <= 4'h0;
            shift_in <= 15'h0000;
            addr     <= 13'h0000;
            len      <= 2'h0;
            byte_cnt <= 2'h0;
            rd_shift <= 8'h00;
            sdio_q   <= 1'b0;
            drive_n  <= 1'b1;
        end else begin
            state    <= next_state;
            bit_cnt  <= next_bit_cnt;
            shift_in <= next_shift_in;
            addr     <= next_addr;
            len      <= next_len;
            byte_cnt <= next_byte_cnt;
            rd_shift <= next_rd_shift;
            sdio_q   <= next_sdio_q;
            drive_n  <= next_drive_n;
        end
    end

    // ============================================================
    // Register writes
    // soft reset request
    assign soft_rst = wr.en && wr.addr == `CCR_ADDR_PORT_CFG && |(wr.data & `CCR_MASK_SOFT_RST);

    always_comb begin
        next_port_cfg = port_cfg;
        next_sel_hi_m = sel_hi_m;
        next_sel_lo_m = sel_lo_m;
        next_sel_hi   = sel_hi;
        next_sel_lo   = sel_lo;
        next_op_mode  = op_mode;
        next_clk_ctrl = clk_ctrl;
        next_upd_pend = 1'b0;
        if (upd_pend) begin
            next_sel_hi = sel_hi_m;
            next_sel_lo = sel_lo_m;
        end
        if (soft_rst) begin
            next_port_cfg = `CCR_RST_PORT_CFG;
            next_sel_hi_m = `CCR_RST_SEL;
            next_sel_lo_m = `CCR_RST_SEL;
            next_sel_hi   = `CCR_RST_SEL;
            next_sel_lo   = `CCR_RST_SEL;
            next_op_mode  = `CCR_RST_OP_MODE;
            next_clk_ctrl = `CCR_RST_CLK_CTRL;
        end else if (wr.en) begin
            case (wr.addr)
                `CCR_ADDR_PORT_CFG:  next_port_cfg = `CCR_RST_PORT_CFG | (wr.data & `CCR_MASK_PORT_ORDER);
                `CCR_ADDR_SEL_UPPER: next_sel_hi_m = wr.data & `CCR_MASK_SEL_UPPER;
                `CCR_ADDR_SEL_LOWER: next_sel_lo_m = wr.data & `CCR_MASK_SEL_LOWER;
                `CCR_ADDR_OP_MODE:   next_op_mode  = wr.data & `CCR_MASK_OP_MODE;
                `CCR_ADDR_CLK_CTRL:  next_clk_ctrl = wr.data & `CCR_MASK_CLK_CTRL;
                // set wins, cleared after one copy
                `CCR_ADDR_UPDATE:    next_upd_pend = wr.data[`CCR_BIT_UPDATE];
                default:             next_upd_pend = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            port_cfg <= `CCR_RST_PORT_CFG;
            sel_hi_m <= `CCR_RST_SEL;
            sel_lo_m <= `CCR_RST_SEL;
            sel_hi   <= `CCR_RST_SEL;
            sel_lo   <= `CCR_RST_SEL;
            op_mode  <= `CCR_RST_OP_MODE;
            clk_ctrl <= `CCR_RST_CLK_CTRL;
            upd_pend <= 1'b0;
        end else begin
            port_cfg <= next_port_cfg;
            sel_hi_m <= next_sel_hi_m;
            sel_lo_m <= next_sel_lo_m;
            sel_hi   <= next_sel_hi;
            sel_lo   <= next_sel_lo;
            op_mode  <= next_op_mode;
            clk_ctrl <= next_clk_ctrl;
            upd_pend <= next_upd_pend;
        end
    end

    // ============================================================
    // Outputs
    // lane enables from slave stage
    assign chan_data_en_o            = {sel_hi[3:0], sel_lo[3:0]};
    assign frame_clock_output_lane_o = sel_lo[`CCR_BIT_FCO];
    assign data_clock_output_lane_o  = sel_lo[`CCR_BIT_DCO];
    assign lsb_first_o               = port_cfg[`CCR_BIT_ORDER_HI];
    assign lna_bypass_o              = op_mode[`CCR_BIT_LNA_BYPASS];
    assign op_mode_o                 = op_mode[2:0];
    assign dcs_en_o                  = clk_ctrl[`CCR_BIT_DCS];
    assign sdio_o                    = sdio_q;
    assign sdio_drive_n_o            = drive_n;

    // ============================================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_upd_copy;
        upd_pend && !soft_rst |=> sel_lo == $past(sel_lo_m) && sel_hi == $past(sel_hi_m);
    endproperty
    a_upd_copy: assert property (p_upd_copy) else $error("update did not copy master");

    property p_slave_hold;
        !upd_pend && !soft_rst |=> $stable(chan_data_en_o) && $stable(data_clock_output_lane_o);
    endproperty
    a_slave_hold: assert property (p_slave_hold) else $error("slave changed without update");

    property p_upd_self_clear;
        upd_pend && !(wr.en && wr.addr == `CCR_ADDR_UPDATE) |=> !upd_pend;
    endproperty
    a_upd_self_clear: assert property (p_upd_self_clear) else $error("update bit stuck");

    property p_soft_rst;
        soft_rst |=> op_mode_o == 3'h0 && dcs_en_o && chan_data_en_o == 8'hFF && port_cfg == 8'h18;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset left non-default state");

    property p_hard_rst;
        disable iff (1'b0) rst_i |=> port_cfg == 8'h18 && sel_lo_m == 8'h0F && clk_ctrl == 8'h01 && !upd_pend;
    endproperty
    a_hard_rst: assert property (p_hard_rst) else $error("reset defaults wrong");

    property p_dcs_write;
        wr.en && wr.addr == `CCR_ADDR_CLK_CTRL |=> dcs_en_o == $past(wr.data[0]) && clk_ctrl[7:1] == 7'h00;
    endproperty
    a_dcs_write: assert property (p_dcs_write) else $error("stabilizer enable not written");

    property p_sel_master;
        wr.en && wr.addr == `CCR_ADDR_SEL_LOWER |=> sel_lo_m == ($past(wr.data) & 8'h3F);
    endproperty
    a_sel_master: assert property (p_sel_master) else $error("lower select master wrong");

    property p_mirror;
        wr.en && wr.addr == `CCR_ADDR_PORT_CFG && wr.data[6] == wr.data[1] && !soft_rst
            |=> lsb_first_o == $past(wr.data[1]) && port_cfg[4:3] == 2'h3;
    endproperty
    a_mirror: assert property (p_mirror) else $error("bit order not taken");

    property p_unmapped;
        ld_event && !mapped(ld_addr) |=> rd_shift == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    c_update: cover property (upd_pend ##1 !upd_pend);
    c_soft:   cover property (soft_rst);
    c_stream: cover property (wr.en && len == 2'h3 && byte_cnt == 2'h2);
    c_read:   cover property (state == CCR_ST_READ && !drive_n);

endmodule : ccr_config_regs

// ===== ccr_pin_sync.sv
// Serial port pin synchroniser and clock edge detector
`timescale 1ns/100ps
module ccr_pin_sync
    import ccr_pkg::*;
(
    input  wire logic      core_clk_i,
    input  wire logic      rst_i,
    input  wire logic      sclk_i,
    input  wire logic      csb_n_i,
    input  wire logic      sdio_i,
    output ccr_pins_s      pins_o
);

    logic [2:0] meta;
    logic [2:0] sync;
    logic       sclk_d;
    logic [2:0] next_meta;
    logic [2:0] next_sync;
    logic       next_sclk_d;

    always_comb begin
        next_meta   = {sdio_i, csb_n_i, sclk_i};
        next_sync   = meta;
        next_sclk_d = sync[0];
    end

    // Idle levels: clock low, chip select released
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            meta   <= 3'h2;
            sync   <= 3'h2;
            sclk_d <= 1'b0;
        end else begin
            meta   <= next_meta;
            sync   <= next_sync;
            sclk_d <= next_sclk_d;
        end
    end

    always_comb begin
        pins_o.sclk_rise = sync[0] & ~sclk_d;
        pins_o.sclk_fall = ~sync[0] & sclk_d;
        pins_o.cs_active = ~sync[1];
        pins_o.sdata     = sync[2];
    end

endmodule : ccr_pin_sync

// ===== ccr_pkg.sv
// Types shared by the configuration register bank modules
package ccr_pkg;

    typedef enum logic [1:0] {
        CCR_ST_INSTR,
        CCR_ST_WRITE,
        CCR_ST_READ,
        CCR_ST_DONE
    } ccr_state_e;

    typedef struct packed {
        logic        sclk_rise;
        logic        sclk_fall;
        logic        cs_active;
        logic        sdata;
    } ccr_pins_s;

    typedef struct packed {
        logic        en;
        logic [12:0] addr;
        logic [7:0]  data;
    } ccr_wr_s;

endpackage : ccr_pkg

// ===== ccr_regs.svh
// Register map constants for the converter configuration register bank
// ============================================================
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// ============================================================
// Offsets
`define CCR_ADDR_PORT_CFG    13'h0000
`define CCR_ADDR_PART_ID     13'h0001
`define CCR_ADDR_GRADE       13'h0002
`define CCR_ADDR_SEL_UPPER   13'h0004
`define CCR_ADDR_SEL_LOWER   13'h0005
`define CCR_ADDR_OP_MODE     13'h0008
`define CCR_ADDR_CLK_CTRL    13'h0009
`define CCR_ADDR_FUNC_LAST   13'h002D
`define CCR_ADDR_UPDATE      13'h00FF

// ============================================================
// Reset values and writable masks
`define CCR_RST_PORT_CFG     8'h18
`define CCR_RST_SEL          8'h0F
`define CCR_RST_OP_MODE      8'h00
`define CCR_RST_CLK_CTRL     8'h01
`define CCR_MASK_PORT_ORDER  8'h42
`define CCR_MASK_SOFT_RST    8'h24
`define CCR_MASK_SEL_UPPER   8'h0F
`define CCR_MASK_SEL_LOWER   8'h3F
`define CCR_MASK_OP_MODE     8'h0F
`define CCR_MASK_CLK_CTRL    8'h01

// ============================================================
// Field positions
`define CCR_BIT_UPDATE       0
`define CCR_BIT_DCS          0
`define CCR_BIT_LNA_BYPASS   3
`define CCR_BIT_FCO          4
`define CCR_BIT_DCO          5
`define CCR_BIT_ORDER_HI     6
`define CCR_BIT_ORDER_LO     1
`define CCR_BIT_INSTR_READ   15
`define CCR_INSTR_LEN_LSB    13

`endif

// ===== ccr_spi_host_model.sv
// Behavioural serial host for the three-wire configuration port
`timescale 1ns/100ps
module ccr_spi_host_model (
    input  wire logic        core_clk_i,
    input  wire logic        start_i,
    input  wire logic        rd_i,
    input  wire logic        lsb_i,
    input  wire logic [12:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic [3:0]  nbits_i,
    input  wire logic [1:0]  len_i,
    input  wire logic        dev_sdio_i,
    input  wire logic        dev_drive_n_i,
    output logic             sclk_o,
    output logic             csb_n_o,
    output logic             sdio_o,
    output logic             done_o,
    output logic [7:0]       rdata_o
);
    logic        host_oe;
    logic        host_bit;
    logic        last_lvl;
    logic        smp;
    logic [15:0] instr;
    // ========
    // Wire level: no pull, so a released line toggles
    assign sdio_o = !dev_drive_n_i ? dev_sdio_i : (host_oe ? host_bit : !last_lvl);
    // Unknown start level folds to low so the toggling line never stays unknown
    always @(posedge core_clk_i) begin
        last_lvl <= (sdio_o === 1'b1);
    end
    // ========
    // Bit cell: six core clocks a phase, oversampled port needs two
    task automatic shift(input logic b, input logic drv);
        @(posedge core_clk_i);
        host_oe  <= drv;
        host_bit <= b;
        repeat (6) @(posedge core_clk_i);
        sclk_o <= 1'b1;
        smp = sdio_o;
        repeat (6) @(posedge core_clk_i);
        sclk_o <= 1'b0;
    endtask : shift
    // ========
    // Frame: len_i+1 data bytes, nbits_i below 8 aborts mid-byte
    task automatic frame();
        instr = {rd_i, len_i, addr_i};
        @(posedge core_clk_i);
        csb_n_o <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            shift(lsb_i ? instr[i] : instr[15-i], 1'b1);
        end
        for (int b = 0; b <= len_i; b++) begin
            for (int i = 0; i < 8 && i < nbits_i; i++) begin
                shift(lsb_i ? wdata_i[i] : wdata_i[7-i], !rd_i);
                rdata_o <= lsb_i ? {smp, rdata_o[7:1]} : {rdata_o[6:0], smp};
            end
        end
        repeat (6) @(posedge core_clk_i);
        csb_n_o <= 1'b1;
        host_oe <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        done_o <= 1'b1;
        @(posedge core_clk_i);
        done_o <= 1'b0;
    endtask : frame
    initial begin
        sclk_o   = 1'b0;
        csb_n_o  = 1'b1;
        host_oe  = 1'b0;
        host_bit = 1'b0;
        smp      = 1'b0;
        done_o   = 1'b0;
        rdata_o  = 8'h00;
        forever begin
            @(posedge core_clk_i);
            if (start_i === 1'b1) begin
                frame();
            end
        end
    end
endmodule : ccr_spi_host_model

// ===== converter_config_register_map_tb_top.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
`include "ccr_regs.svh"
module converter_config_register_map_tb_top;
    localparam logic [7:0] TB_PART_ID = 8'hC3;  // Arbitrary value
    localparam logic [1:0] TB_GRADE   = 2'h1;   // Arbitrary value
    logic        core_clk_i, rst_i, start, rd, lsb, lsb_sel, done;
    logic        sclk, csb_n, sdio_wire, sdio_dev, sdio_drive_n;
    logic        lsb_first, fco_en, dco_en, bypass, dcs_en;
    logic [12:0] addr;
    logic [7:0]  wdata, rdata, chan_en, up, lo, d;
    logic [3:0]  nbits;
    logic [1:0]  blen, blen_sel;
    logic [2:0]  mode;
    logic [15:0] seed;
    logic [7:0]  exp_q[$];
    int          error_cnt, n_checks;
    ccr_config_regs #(.PART_ID(TB_PART_ID), .GRADE_VARIANT(TB_GRADE)) u_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk), .csb_n_i(csb_n),
        .sdio_i(sdio_wire), .sdio_o(sdio_dev), .sdio_drive_n_o(sdio_drive_n),
        .lsb_first_o(lsb_first), .chan_data_en_o(chan_en), .frame_clock_output_lane_o(fco_en),
        .data_clock_output_lane_o(dco_en), .lna_bypass_o(bypass), .op_mode_o(mode), .dcs_en_o(dcs_en)
    );
    ccr_spi_host_model u_host (
        .core_clk_i(core_clk_i), .start_i(start), .rd_i(rd), .lsb_i(lsb), .addr_i(addr),
        .wdata_i(wdata), .nbits_i(nbits), .len_i(blen), .dev_sdio_i(sdio_dev), .dev_drive_n_i(sdio_drive_n),
        .sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(sdio_wire), .done_o(done), .rdata_o(rdata)
    );
    // ========
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic outs(input logic l, input logic [7:0] c, input logic [1:0] k, input logic [3:0] m,
                        input logic s);
        chk({lsb_first, chan_en, dco_en, fco_en, bypass, mode, dcs_en}, {l, c, k, m, s}, "outputs");
    endtask : outs
    task automatic xfer(input logic r, input logic [12:0] a, input logic [7:0] dt, input logic [3:0] nb);
        int n;
        @(posedge core_clk_i);
        rd    <= r;
        addr  <= a;
        wdata <= dt;
        nbits <= nb;
        lsb   <= lsb_sel;
        blen  <= blen_sel;
        start <= 1'b1;
        @(posedge core_clk_i);
        start <= 1'b0;
        for (n = 0; n < 1000 && done !== 1'b1; n++) @(posedge core_clk_i);
        if (n == 1000) chk(16'h0, 16'h1, "frame hang");
        repeat (4) @(posedge core_clk_i);
    endtask : xfer
    task automatic wr(input logic [12:0] a, input logic [7:0] dt);
        xfer(1'b0, a, dt, 4'h8);
    endtask : wr
    task automatic rdc(input logic [12:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        xfer(1'b1, a, 8'h00, 4'h8);
    endtask : rdc
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    // ========
    // Clock, watchdog and read-data monitor
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (40000) @(posedge core_clk_i);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end
    always @(posedge core_clk_i) begin
        if (done === 1'b1 && rd === 1'b1) begin
            if (exp_q.size() == 0) chk(16'h0, 16'h1, "unexpected read");
            else chk({8'h00, rdata}, {8'h00, exp_q.pop_front()}, "read data");
        end
    end
    // ========
    // Tests
    initial begin
        rst_i = 1'b1;
        start = 1'b0;
        rd = 1'b0;
        lsb = 1'b0;
        lsb_sel = 1'b0;
        addr = 13'h0000;
        wdata = 8'h00;
        nbits = 4'h8;
        blen = 2'h0;
        blen_sel = 2'h0;
        error_cnt = 0;
        n_checks = 0;
        seed = 16'hC8E8;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        outs(1'b0, 8'hFF, 2'h0, 4'h0, 1'b1);
        rdc(`CCR_ADDR_PORT_CFG, 8'h18);
        rdc(`CCR_ADDR_PART_ID, TB_PART_ID);
        rdc(`CCR_ADDR_GRADE, {2'h0, TB_GRADE, 4'h0});
        rdc(`CCR_ADDR_SEL_UPPER, 8'h0F);
        rdc(`CCR_ADDR_SEL_LOWER, 8'h0F);
        rdc(`CCR_ADDR_OP_MODE, 8'h00);
        rdc(`CCR_ADDR_CLK_CTRL, 8'h01);
        rdc(`CCR_ADDR_UPDATE, 8'h00);
        rdc(13'h0003, 8'h00);
        wr(13'h0003, 8'h00);
        rdc(13'h0003, 8'h00);
        chk({15'h0, sdio_drive_n}, 16'h1, "port released");
        $display("test reset values done");
        xfer(1'b0, `CCR_ADDR_CLK_CTRL, 8'h00, 4'h4);
        outs(1'b0, 8'hFF, 2'h0, 4'h0, 1'b1);
        wr(`CCR_ADDR_CLK_CTRL, 8'h00);
        outs(1'b0, 8'hFF, 2'h0, 4'h0, 1'b0);
        rdc(`CCR_ADDR_CLK_CTRL, 8'h00);
        wr(`CCR_ADDR_PART_ID, 8'h00);
        rdc(`CCR_ADDR_PART_ID, TB_PART_ID);
        $display("test abort and stabilizer done");
        for (int m = 0; m < 5; m++) begin
            seed = lfsr_next(seed);
            d = {4'h0, seed[0], m[2:0]};
            wr(`CCR_ADDR_OP_MODE, d);
            outs(1'b0, 8'hFF, 2'h0, d[3:0], 1'b0);
            rdc(`CCR_ADDR_OP_MODE, d);
        end
        $display("test modes done");
        seed = lfsr_next(seed);
        up = {5'h00, seed[2:0]};
        lo = {2'h0, 2'h3, seed[7:4]};
        wr(`CCR_ADDR_SEL_UPPER, up);
        wr(`CCR_ADDR_SEL_LOWER, lo);
        outs(1'b0, 8'hFF, 2'h0, d[3:0], 1'b0);
        rdc(`CCR_ADDR_SEL_UPPER, up);
        rdc(`CCR_ADDR_SEL_LOWER, lo);
        wr(`CCR_ADDR_UPDATE, 8'h01);
        outs(1'b0, {up[3:0], lo[3:0]}, lo[5:4], d[3:0], 1'b0);
        rdc(`CCR_ADDR_UPDATE, 8'h00);
        $display("test shadow update done");
        wr(`CCR_ADDR_SEL_UPPER, 8'h00);
        wr(`CCR_ADDR_PORT_CFG, 8'h3C);
        outs(1'b0, 8'hFF, 2'h0, 4'h0, 1'b1);
        rdc(`CCR_ADDR_PORT_CFG, 8'h18);
        rdc(`CCR_ADDR_SEL_UPPER, 8'h0F);
        $display("test soft reset done");
        // Two-byte frames step the address down from the one named
        blen_sel = 2'h1;
        wr(`CCR_ADDR_CLK_CTRL, 8'h01);
        outs(1'b0, 8'hFF, 2'h0, 4'h1, 1'b1);
        rdc(`CCR_ADDR_OP_MODE, 8'h00);
        blen_sel = 2'h0;
        rdc(`CCR_ADDR_OP_MODE, 8'h01);
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        outs(1'b0, 8'hFF, 2'h0, 4'h0, 1'b1);
        rdc(`CCR_ADDR_OP_MODE, 8'h00);
        $display("test multi-byte and reset done");
        wr(`CCR_ADDR_PORT_CFG, 8'h5A);
        outs(1'b1, 8'hFF, 2'h0, 4'h0, 1'b1);
        lsb_sel = 1'b1;
        wr(`CCR_ADDR_OP_MODE, 8'h0B);
        outs(1'b1, 8'hFF, 2'h0, 4'hB, 1'b1);
        rdc(`CCR_ADDR_OP_MODE, 8'h0B);
        wr(`CCR_ADDR_PORT_CFG, 8'h18);
        lsb_sel = 1'b0;
        outs(1'b0, 8'hFF, 2'h0, 4'hB, 1'b1);
        rdc(`CCR_ADDR_PORT_CFG, 8'h18);
        $display("test bit order done");
        close_out();
    end
endmodule : converter_config_register_map_tb_top
